// ---- hdl/icspf_defs.vh ----
// Constants for the instruction cache speculative prefetch controller
`ifndef ICSPF_DEFS_VH
`define ICSPF_DEFS_VH
`define ICSPF_AW          32
`define ICSPF_LINE_LSB    5
`define ICSPF_REGION_LSB  10
`define ICSPF_DW_PER_LINE 3'h4
`define ICSPF_MAX_SPEC    2'h3
`define ICSPF_S_IDLE      3'h0
`define ICSPF_S_LOOK      3'h1
`define ICSPF_S_DEMREQ    3'h2
`define ICSPF_S_DEMDATA   3'h3
`define ICSPF_S_BURSTREQ  3'h4
`define ICSPF_S_BURSTDATA 3'h5
`endif

// ---- hdl/icspf_dw_count.v ----
// Beat counter for the line currently being filled
`timescale 1ns/1ns
`default_nettype none
module icspf_dw_count #(
	parameter W = 3
) (
	input  wire         mclk,
	input  wire         clear,
	input  wire         beat,
	output wire         last,
	output reg  [W-1:0] count_r
);
	assign last = beat && (count_r == 3'h3);
	always @(posedge mclk) begin
		if (clear || last)
			count_r <= {W{1'b0}};
		else if (beat)
			count_r <= count_r + 3'h1;
	end
endmodule
`default_nettype wire

// ---- hdl/icspf_ctrl.v ----
// Speculative line prefetch and fill abandonment controller
`timescale 1ns/1ns
`default_nettype none
`include "icspf_defs.vh"
module icspf_ctrl #(
	parameter AW = `ICSPF_AW
) (
	input  wire          mclk,
	input  wire          reset,
	input  wire          fetch_valid,
	input  wire [AW-1:0] fetch_addr,
	input  wire          fetch_hit,
	input  wire          fetch_cacheable,
	input  wire          prefetch_enable,
	input  wire [1:0]    prefetch_line_count,
	input  wire [1:0]    prefetch_abandon_threshold,
	output reg           probe_valid_r,
	output reg  [AW-1:0] probe_addr_r,
	input  wire          probe_hit,
	output reg           rd_req_r,
	output reg  [AW-1:0] rd_addr_r,
	output reg           rd_burst_r,
	output reg  [1:0]    rd_lines_r,
	input  wire          rd_ack,
	input  wire          rd_dvalid,
	input  wire [127:0]  rd_data,
	output reg           rd_terminate_r,
	output reg           fill_wr_r,
	output reg  [AW-1:0] fill_addr_r,
	output reg  [255:0]  line_fill_buffer,
	output reg  [3:0]    fill_dw_valid_r,
	output reg           fill_abandoned_r
);
	reg [2:0]    state_r;
	reg [AW-1:0] miss_addr_r;
	reg [AW-1:0] cur_addr_r;
	reg [1:0]    want_r;
	reg [1:0]    probed_r;
	reg [1:0]    lines_left_r;
	reg          kill_r;
	reg          cacheable_r;
	reg          pend_r;
	reg [AW-1:0] pend_addr_r;
	reg          pend_cache_r;
	reg          dem_done_r;
	wire         cache_sel;
	wire [4:0]   edge_gap;
	wire         probing;
	wire         probe_more;
	wire         probe_done;
	wire [1:0]   spec_lines;
	wire         beat;
	wire         line_done;
	wire [2:0]   dw_cnt;
	wire         new_miss;
	wire [AW-1:0] next_line;
	wire [2:0]   room;
	wire [1:0]   want_nxt;
	wire         in_data;
	wire         keep_line;

	////////////////////////////////////////////////////////////////
	// One 128-bit beat carries two doublewords
	assign in_data  = (state_r == `ICSPF_S_LOOK) ||
		(state_r == `ICSPF_S_DEMDATA) ||
		(state_r == `ICSPF_S_BURSTDATA);
	assign beat     = in_data && rd_dvalid;
	assign new_miss = fetch_valid && !fetch_hit;
	assign next_line = cur_addr_r + 32'h20;
	// Lines left before the 1KB boundary; avoids an MMU lookup
	assign edge_gap = 5'h1f - miss_addr_r[9:5];
	assign room = (edge_gap > 5'h03) ? 3'h3 : edge_gap[2:0];
	assign cache_sel = pend_r ? pend_cache_r : fetch_cacheable;
	assign want_nxt = (!prefetch_enable || !cache_sel) ? 2'h0 :
		prefetch_line_count;
	// Probes run while the demand line streams in
	assign probing = (state_r == `ICSPF_S_LOOK) ||
		(state_r == `ICSPF_S_DEMDATA);
	assign probe_more = (probed_r < want_r) &&
		({1'b0, probed_r} < room);
	assign probe_done = !probe_valid_r && !probe_more;
	assign spec_lines = ({1'b0, want_r} > room) ? room[1:0] : want_r;
	// Threshold counts doublewords, two per beat
	assign keep_line = ({dw_cnt[1:0], 1'b0} >=
		{1'b0, prefetch_abandon_threshold});

	icspf_dw_count #(.W(3)) u_cnt (
		.mclk    (mclk),
		.clear   (reset || (state_r == `ICSPF_S_BURSTREQ) ||
			(state_r == `ICSPF_S_DEMREQ) || line_done),
		.beat    (beat),
		.last    (),
		.count_r (dw_cnt)
	);
	assign line_done = beat && (dw_cnt == 3'h1);

	////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		if (reset) begin
			state_r          <= `ICSPF_S_IDLE;
			miss_addr_r      <= 32'h0;
			cur_addr_r       <= 32'h0;
			want_r           <= 2'h0;
			probed_r         <= 2'h0;
			lines_left_r     <= 2'h0;
			kill_r           <= 1'b0;
			cacheable_r      <= 1'b0;
			pend_r           <= 1'b0;
			pend_addr_r      <= 32'h0;
			pend_cache_r     <= 1'b0;
			dem_done_r       <= 1'b0;
			probe_valid_r    <= 1'b0;
			probe_addr_r     <= 32'h0;
			rd_req_r         <= 1'b0;
			rd_addr_r        <= 32'h0;
			rd_burst_r       <= 1'b0;
			rd_lines_r       <= 2'h0;
			rd_terminate_r   <= 1'b0;
			fill_wr_r        <= 1'b0;
			fill_addr_r      <= 32'h0;
			line_fill_buffer <= 256'h0;
			fill_dw_valid_r  <= 4'h0;
			fill_abandoned_r <= 1'b0;
		end else begin
			fill_wr_r      <= 1'b0;
			rd_terminate_r <= 1'b0;
			probe_valid_r  <= 1'b0;
			// Miss during fill: decide what survives
			if (new_miss && state_r != `ICSPF_S_IDLE) begin
				pend_r       <= 1'b1;
				pend_addr_r  <= fetch_addr;
				pend_cache_r <= fetch_cacheable;
				if (state_r == `ICSPF_S_LOOK)
					want_r <= 2'h0;
				if (state_r == `ICSPF_S_DEMDATA ||
					state_r == `ICSPF_S_DEMREQ)
					want_r <= 2'h0;
				// A presented burst is never withdrawn, only cut
				if (state_r == `ICSPF_S_BURSTDATA ||
					state_r == `ICSPF_S_BURSTREQ) begin
					lines_left_r <= 2'h0;
					if (!keep_line)
						kill_r <= 1'b1;
				end
			end
			if (probing && !probe_valid_r && probe_more) begin
				probe_valid_r <= 1'b1;
				probe_addr_r  <= {miss_addr_r[AW-1:5], 5'h0} +
					{25'h0, probed_r + 2'h1, 5'h0};
			end
			if (probe_valid_r) begin
				probed_r <= probed_r + 2'h1;
				// Stop at the first resident line; burst is contiguous
				if (probe_hit && !new_miss)
					want_r <= probed_r;
			end
			case (state_r)
			`ICSPF_S_IDLE: begin
				if (pend_r || new_miss) begin
					miss_addr_r <= pend_r ? pend_addr_r : fetch_addr;
					cur_addr_r  <= pend_r ? pend_addr_r : fetch_addr;
					cacheable_r <= pend_r ? pend_cache_r : fetch_cacheable;
					want_r      <= want_nxt;
					pend_r      <= 1'b0;
					rd_req_r    <= 1'b1;
					rd_addr_r   <= pend_r ? pend_addr_r : fetch_addr;
					rd_burst_r  <= 1'b0;
					rd_lines_r  <= 2'h0;
					state_r     <= `ICSPF_S_DEMREQ;
				end
			end
			`ICSPF_S_DEMREQ: begin
				if (rd_ack) begin
					rd_req_r <= 1'b0;
					probed_r <= 2'h0;
					kill_r   <= 1'b0;
					dem_done_r       <= 1'b0;
					fill_dw_valid_r  <= 4'h0;
					fill_abandoned_r <= 1'b0;
					state_r  <= `ICSPF_S_LOOK;
				end
			end
			`ICSPF_S_LOOK: begin
				if (beat)
					state_r <= `ICSPF_S_DEMDATA;
			end
			`ICSPF_S_DEMDATA: begin
				if (line_done) begin
					dem_done_r <= 1'b1;
					if (cacheable_r)
						fill_wr_r <= 1'b1;
				end
				// Burst waits for the probes to settle
				if ((line_done || dem_done_r) && probe_done) begin
					dem_done_r <= 1'b0;
					if (spec_lines != 2'h0 && !pend_r) begin
						rd_req_r     <= 1'b1;
						rd_burst_r   <= 1'b1;
						rd_lines_r   <= spec_lines;
						rd_addr_r    <= {next_line[AW-1:5], 5'h0};
						cur_addr_r   <= next_line;
						lines_left_r <= spec_lines;
						state_r      <= `ICSPF_S_BURSTREQ;
					end else
						state_r <= `ICSPF_S_IDLE;
				end
			end
			`ICSPF_S_BURSTREQ: begin
				if (rd_ack) begin
					rd_req_r <= 1'b0;
					fill_dw_valid_r  <= 4'h0;
					fill_abandoned_r <= 1'b0;
					state_r <= `ICSPF_S_BURSTDATA;
				end
			end
			`ICSPF_S_BURSTDATA: begin
				if (kill_r) begin
					rd_terminate_r   <= 1'b1;
					fill_abandoned_r <= 1'b1;
					kill_r  <= 1'b0;
					state_r <= `ICSPF_S_IDLE;
				end else if (line_done) begin
					fill_wr_r <= 1'b1;
					if (lines_left_r <= 2'h1) begin
						rd_terminate_r <= (lines_left_r == 2'h0);
						state_r <= `ICSPF_S_IDLE;
					end else begin
						lines_left_r <= lines_left_r - 2'h1;
						cur_addr_r   <= next_line;
					end
				end
			end
			default: state_r <= `ICSPF_S_IDLE;
			endcase
			// Beats overwrite the buffer; older partial data is lost
			if (beat && !kill_r) begin
				if (dw_cnt[0] == 1'b0) begin
					line_fill_buffer[127:0] <= rd_data;
					fill_addr_r <= {cur_addr_r[AW-1:5], 5'h0};
					fill_dw_valid_r[1:0]    <= 2'h3;
					fill_dw_valid_r[3:2]    <= 2'h0;
				end else begin
					line_fill_buffer[255:128] <= rd_data;
					fill_dw_valid_r[3:2]      <= 2'h3;
				end
			end
		end
	end
	// Coherency is left to software invalidation
endmodule
`default_nettype wire

// ---- bench/icspf_ctrl_assertions.sv ----
// Port checker for the speculative prefetch controller
`timescale 1ns/1ns
`default_nettype none
module icspf_ctrl_assertions (
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic        probe_valid_r,
	input wire logic [31:0] probe_addr_r,
	input wire logic        rd_req_r,
	input wire logic [31:0] rd_addr_r,
	input wire logic        rd_burst_r,
	input wire logic [1:0]  rd_lines_r,
	input wire logic        rd_ack,
	input wire logic        rd_dvalid,
	input wire logic        fill_wr_r,
	input wire logic [31:0] fill_addr_r,
	input wire logic [3:0]  fill_dw_valid_r,
	input wire logic        fill_abandoned_r
);
	logic dem_acked_r;
	always @(posedge mclk) begin
		if (reset)
			dem_acked_r <= 1'b0;
		else if (rd_ack)
			dem_acked_r <= !rd_burst_r;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	req_hold_a: assert property (rd_req_r && !rd_ack |=>
		rd_req_r && $stable(rd_addr_r)) else $error("request dropped");
	burst_start_a: assert property (rd_req_r && rd_burst_r |->
		rd_addr_r[9:5] != 5'h0) else $error("burst left region");
	region_end_a: assert property (rd_req_r && rd_burst_r |->
		{1'b0, rd_addr_r[9:5]} + rd_lines_r <= 6'h20) else $error("past edge");
	burst_after_a: assert property ($rose(rd_req_r) && rd_burst_r |->
		dem_acked_r) else $error("burst before demand ack");
	probe_region_a: assert property (probe_valid_r |->
		probe_addr_r[9:5] != 5'h0) else $error("probe past edge");
	fill_full_a: assert property (fill_wr_r |-> fill_dw_valid_r == 4'hf
		&& !fill_abandoned_r) else $error("partial line written");
	dw_pairs_a: assert property (fill_dw_valid_r
		inside {4'h0, 4'h3, 4'hf}) else $error("bad doubleword valids");
	fill_align_a: assert property (fill_wr_r |->
		fill_addr_r[4:0] == 5'h0) else $error("unaligned line write");
endmodule
bind icspf_ctrl icspf_ctrl_assertions icspf_ctrl_assertions_inst (.mclk,
	.reset, .probe_valid_r, .probe_addr_r, .rd_req_r, .rd_addr_r,
	.rd_burst_r, .rd_lines_r, .rd_ack, .rd_dvalid, .fill_wr_r,
	.fill_addr_r, .fill_dw_valid_r, .fill_abandoned_r);
`default_nettype wire

// ---- bench/icspf_mem_model.sv ----
// Memory side model answering line and burst reads
`timescale 1ns/1ns
`default_nettype none
module icspf_mem_model (
	input  wire logic [1:0]   gap_len,
	input  wire logic         mclk,
	input  wire logic         reset,
	input  wire logic         rd_req_r,
	input  wire logic [31:0]  rd_addr_r,
	input  wire logic         rd_burst_r,
	input  wire logic [1:0]   rd_lines_r,
	input  wire logic         rd_terminate_r,
	output var  logic         rd_ack,
	output var  logic         rd_dvalid,
	output var  logic [127:0] rd_data
);
	logic [2:0]  left_r;
	logic [1:0]  gap_r;
	logic [31:0] addr_r;
	always @(posedge mclk) begin
		rd_ack <= 1'b0;
		rd_dvalid <= 1'b0;
		// Idle bus inverts rd_data every cycle rather than holding the last beat
		rd_data <= ~rd_data;
		if (reset) begin
			left_r <= 3'h0;
			rd_data <= 128'h0;
		end else if (rd_terminate_r) begin
			left_r <= 3'h0;
		end else if (left_r != 3'h0) begin
			gap_r <= gap_r - 2'h1;
			if (gap_r == 2'h0) begin
				rd_dvalid <= 1'b1;
				rd_data <= {4{addr_r}};
				addr_r <= addr_r + 32'h10;
				left_r <= left_r - 3'h1;
				gap_r <= gap_len;
			end
		end else if (rd_req_r && !rd_ack) begin
			rd_ack <= 1'b1;
			addr_r <= {rd_addr_r[31:5], 5'h0};
			left_r <= rd_burst_r ? {rd_lines_r, 1'b0} : 3'h2;
			gap_r <= gap_len;
		end
	end
endmodule
`default_nettype wire

// ---- bench/icspf_ctrl_bench.sv ----
// Self-checking bench for the speculative prefetch controller
`timescale 1ns/1ns
`default_nettype none
module icspf_ctrl_bench;
	logic	mclk = 0, reset = 1, fetch_valid = 0, fetch_hit = 0, aband;
	logic	fetch_cacheable = 1, prefetch_enable = 1, probe_hit;
	logic	probe_valid_r, rd_req_r, rd_burst_r, rd_ack, rd_dvalid;
	logic	rd_terminate_r, fill_wr_r, fill_abandoned_r;
	logic [1:0]	prefetch_line_count = 0, prefetch_abandon_threshold = 0;
	logic [1:0]	rd_lines_r, lines, gap_len = 0;
	logic [31:0]	fetch_addr = 0, probe_addr_r, rd_addr_r, fill_addr_r, l;
	logic [127:0]	rd_data;
	logic [255:0]	line_fill_buffer;
	logic [3:0]	fill_dw_valid_r;
	logic [4:0]	hit_line = 0;
	int	bad_count = 0, num_checks = 0, beats, bursts;
	// Rows: address, line count, enable, cacheable, resident line, lines
	localparam logic [26:0] rows [8] = '{
		{16'h1000, 4'hf, 5'h0, 2'h3}, {16'h1008, 4'h7, 5'h0, 2'h1},
		{16'h1000, 4'h3, 5'h0, 2'h0}, {16'h1000, 4'hd, 5'h0, 2'h0},
		{16'h1000, 4'he, 5'h0, 2'h0}, {16'h13c0, 4'hf, 5'h0, 2'h1},
		{16'h13e4, 4'hf, 5'h0, 2'h0}, {16'h1000, 4'hf, 5'h2, 2'h1}};
	assign probe_hit = probe_valid_r && hit_line != 5'h0
		&& probe_addr_r[9:5] == hit_line;
	icspf_ctrl icspf_ctrl_inst (.mclk, .reset, .fetch_valid, .fetch_addr,
		.fetch_hit, .fetch_cacheable, .prefetch_enable, .prefetch_line_count,
		.prefetch_abandon_threshold, .probe_valid_r, .probe_addr_r, .probe_hit,
		.rd_req_r, .rd_addr_r, .rd_burst_r, .rd_lines_r, .rd_ack, .rd_dvalid,
		.rd_data, .rd_terminate_r, .fill_wr_r, .fill_addr_r, .line_fill_buffer,
		.fill_dw_valid_r, .fill_abandoned_r);
	icspf_mem_model icspf_mem_model_inst (.gap_len, .mclk, .reset, .rd_req_r,
		.rd_addr_r, .rd_burst_r, .rd_lines_r, .rd_terminate_r, .rd_ack,
		.rd_dvalid, .rd_data);
	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		beats <= beats + rd_dvalid;
		if (rd_ack && rd_burst_r) begin
			bursts <= bursts + 1;
			lines <= rd_lines_r;
		end
		if (fill_abandoned_r) aband <= 1'b1;
	end
	task automatic chk(string n, logic [255:0] e, logic [255:0] s);
		num_checks++;
		if (e !== s) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic fetch(logic [31:0] a, logic h);
		beats = 0;
		bursts = 0;
		lines = 0;
		aband = 0;
		fetch_addr = a;
		fetch_hit = h;
		fetch_valid = 1'b1;
		tick(1);
		fetch_valid = 1'b0;
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		#50000;
		bad_count++;
		report_and_stop;
	end
	initial begin
		tick(10);
		reset = 0;
		chk("idle", 0, {rd_req_r, probe_valid_r, fill_wr_r, fill_dw_valid_r});
		foreach (rows[k]) begin
			{prefetch_line_count, prefetch_enable, fetch_cacheable} = rows[k][10:7];
			hit_line = rows[k][6:2];
			l = {16'h0, rows[k][26:16], 5'h0};
			fetch(l | rows[k][15:11], 1'b0);
			for (int i = 0; i < 40 && rd_dvalid !== 1'b1; i++) tick(1);
			fetch(32'h8000, 1'b1);
			for (int i = 0; i < 40 && fill_dw_valid_r !== 4'hf; i++) tick(1);
			chk("buffer", {{4{l + 32'h10}}, {4{l}}}, line_fill_buffer);
			tick(40);
			chk("lines", rows[k][1:0], lines);
			chk("beats", 2 + 2 * rows[k][1:0], beats);
			$display("row %0d done", k);
		end
		hit_line = 5'h0;
		gap_len = 2'h3;
		fetch(32'h2000, 1'b0);
		for (int i = 0; i < 40 && rd_ack !== 1'b1; i++) tick(1);
		fetch(32'h3000, 1'b0);
		tick(150);
		chk("beats", 10, beats);
		chk("bursts", 1, bursts);
		$display("cancel test done");
		for (int t = 0; t < 4; t++) begin
			prefetch_abandon_threshold = t[1:0];
			fetch(32'h4000, 1'b0);
			for (int i = 0; i < 90 && beats < 3; i++) tick(1);
			fetch(32'h5000, 1'b0);
			tick(150);
			chk("beats", t == 3 ? 8 : 9, beats);
			chk("abandoned", t == 3, aband);
			$display("threshold %0d test done", t);
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
